// file: core/fwp_pkg.sv
package fwp_pkg;

  localparam int FWP_WORD_W = 16;
  localparam int FWP_SHIFT_W = 4;
  localparam int FWP_LEN_W = 5;
  localparam int FWP_OFS_W = 12;
  localparam int FWP_RES_W = 17;
  localparam int FWP_PATHS = 2;

  localparam logic [4:0]  FWP_LEN_MIN   = 5'h01;
  localparam logic [4:0]  FWP_LEN_MAX   = 5'h10;
  localparam logic [3:0]  FWP_SHIFT_RST = 4'h0;
  localparam logic [4:0]  FWP_LEN_RST   = 5'h10;
  localparam logic [11:0] FWP_OFS_RST   = 12'h000;
  localparam logic [15:0] FWP_WORD_RST  = 16'h0000;
  localparam logic [16:0] FWP_RES_RST   = 17'h00000;
  localparam logic [16:0] FWP_ONE_RES   = 17'h00001;

  // Cycles the configure operation holds the sequencer
  localparam logic [5:0]  FWP_CFG_CYC   = 6'h04;
  localparam logic [5:0]  FWP_CNT_ONE   = 6'h01;
  localparam logic [5:0]  FWP_CNT_ZERO  = 6'h00;
  // Least waveform length that hides the configure stall
  localparam int FWP_GAPFREE_SAMPLES = 48;

  typedef enum logic [2:0] {
    FWP_SRC_RAW        = 3'h0,
    FWP_SRC_PROC_A     = 3'h1,
    FWP_SRC_PROC_B     = 3'h2,
    FWP_SRC_LEGACY_FWD = 3'h3,
    FWP_SRC_LEGACY_DEC = 3'h4
  } fwp_src_t;

  typedef enum logic {
    FWP_ST_IDLE = 1'b0,
    FWP_ST_CFG  = 1'b1
  } fwp_state_t;

  function automatic logic fwp_is_proc(input fwp_src_t s);
    return (s == FWP_SRC_PROC_A) || (s == FWP_SRC_PROC_B) ||
           (s == FWP_SRC_LEGACY_FWD) || (s == FWP_SRC_LEGACY_DEC);
  endfunction

  function automatic logic fwp_path_of(input fwp_src_t s);
    return (s == FWP_SRC_PROC_B) || (s == FWP_SRC_LEGACY_DEC);
  endfunction

endpackage

// file: core/fwp_path_if.sv
`timescale 1ns/1ns
interface fwp_path_if;
  import fwp_pkg::*;
  logic                   load;
  logic [FWP_SHIFT_W-1:0] shift;
  logic [FWP_LEN_W-1:0]   length;
  logic [FWP_OFS_W-1:0]   offset;
  logic [FWP_WORD_W-1:0]  word;
  logic [FWP_RES_W-1:0]   result;
  logic                   configured;

  modport ctrl (
    output load, shift, length, offset, word,
    input  result, configured
  );
  modport path (
    input  load, shift, length, offset, word,
    output result, configured
  );
endinterface

// file: core/fwp_hold.sv
`timescale 1ns/1ns
module fwp_hold
  import fwp_pkg::*;
(
  // Clock and reset
  input  logic                  clk_i,
  input  logic                  rst_i,
  // Link side
  input  logic                  valid_i,
  input  logic [FWP_WORD_W-1:0] word_i,
  // Held word
  output logic [FWP_WORD_W-1:0] word_o,
  output logic                  seen_o
);

  logic [FWP_WORD_W-1:0] word_reg;
  logic [FWP_WORD_W-1:0] word_next;
  logic                  seen_reg;
  logic                  seen_next;

  always_comb begin
    word_next = word_reg;
    seen_next = seen_reg;
    if (valid_i) begin // RL17
      word_next = word_i; // RL1
      seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_reg <= FWP_WORD_RST;
      seen_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      seen_reg <= seen_next;
    end
  end

  assign word_o = word_reg;
  assign seen_o = seen_reg;

  chk_word_update: assert property ( // RL17
    @(posedge clk_i) disable iff (rst_i)
    valid_i |=> (word_o == $past(word_i)) && seen_o)
    else $error("held word not replaced by new message");

  chk_word_retained: assert property ( // RL12
    @(posedge clk_i) disable iff (rst_i)
    !valid_i |=> $stable(word_o))
    else $error("held word changed without a message");

endmodule // fwp_hold

// file: core/fwp_path.sv
`timescale 1ns/1ns
module fwp_path
  import fwp_pkg::*;
(
  // Clock and reset
  input  logic       clk_i,
  input  logic       rst_i,
  // Settings, word and result
  fwp_path_if.path   bus
);

  logic [FWP_SHIFT_W-1:0] shift_reg;
  logic [FWP_SHIFT_W-1:0] shift_next;
  logic [FWP_LEN_W-1:0]   len_reg;
  logic [FWP_LEN_W-1:0]   len_next;
  logic [FWP_OFS_W-1:0]   ofs_reg;
  logic [FWP_OFS_W-1:0]   ofs_next;
  logic                   conf_reg;
  logic                   conf_next;
  logic [FWP_WORD_W-1:0]  shifted;
  logic [FWP_RES_W-1:0]   mask;

  always_comb begin
    shift_next = shift_reg;
    len_next   = len_reg;
    ofs_next   = ofs_reg;
    conf_next  = conf_reg;
    if (bus.load) begin // RL9 RL11
      shift_next = bus.shift;
      len_next   = bus.length;
      ofs_next   = bus.offset;
      conf_next  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= FWP_SHIFT_RST;
      len_reg   <= FWP_LEN_RST;
      ofs_reg   <= FWP_OFS_RST;
      conf_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      len_reg   <= len_next;
      ofs_reg   <= ofs_next;
      conf_reg  <= conf_next;
    end
  end

  assign shifted = bus.word >> shift_reg; // RL4
  assign mask    = (FWP_ONE_RES << len_reg) - FWP_ONE_RES; // RL5

  always_comb begin
    if (conf_reg) begin
      bus.result = ({1'b0, shifted} & mask) + {5'h00, ofs_reg}; // RL6
    end else begin
      bus.result = {1'b0, bus.word}; // RL8
    end
  end

  assign bus.configured = conf_reg;

  chk_unconf_pass: assert property ( // RL8
    @(posedge clk_i) disable iff (rst_i)
    !bus.configured |-> bus.result == {1'b0, bus.word})
    else $error("unconfigured path altered the word");

  chk_result_range: assert property ( // RL5
    @(posedge clk_i) disable iff (rst_i)
    bus.configured |->
      (bus.result - {5'h00, ofs_reg}) < (FWP_ONE_RES << len_reg))
    else $error("processed value exceeds length mask plus offset");

  chk_params_hold: assert property ( // RL3
    @(posedge clk_i) disable iff (rst_i)
    !bus.load |=> $stable(shift_reg) && $stable(len_reg) &&
                  $stable(ofs_reg))
    else $error("path settings changed without a load");

endmodule // fwp_path

// file: core/fwp_top.sv
// Summary of operation
// RL1 - Link feedback is one 16-bit word
// RL2 - Raw source returns word exactly as received
// RL3 - Two processed paths, separate settings each
// RL4 - Path right-shifts word by 0 to 15
// RL5 - Then masks to length bits, 1 to 16
// RL6 - Then adds offset from 0 to 4095
// RL7 - Configurer keeps length at most 12 for tables; configure accepts lengths up to 16 (FWP_LEN_MAX)
// RL8 - Unconfigured path passes word unchanged
// RL9 - Configure takes selector and updates only it
// RL10 - Configure blocks sequencer while it runs
// RL11 - Settings may change between feedback reads
// RL12 - Last word kept for rereads after reconfigure
// RL13 - Legacy selectors alias paths A and B
// RL14 - Every read names source, own chain each
// RL15 - Value read for branching or table play
// RL16 - Processed value with offset is table index
// RL17 - Each new link message replaces held word
`timescale 1ns/1ns
module fwp_top
  import fwp_pkg::*;
(
  // Clock and reset
  input  logic                   clk_i,
  input  logic                   rst_i,
  // Feedback link
  input  logic                   link_valid_i,
  input  logic [FWP_WORD_W-1:0]  link_word_i,
  // Configure operation
  input  logic                   cfg_req_i,
  input  fwp_src_t               cfg_path_i,
  input  logic [FWP_SHIFT_W-1:0] cfg_shift_i,
  input  logic [FWP_LEN_W-1:0]   cfg_length_i,
  input  logic [FWP_OFS_W-1:0]   cfg_offset_i,
  output logic                   cfg_ready_o,
  output logic                   cfg_busy_o,
  output logic                   cfg_done_o,
  output logic                   cfg_error_o,
  // Feedback read and table play
  input  logic                   rd_req_i,
  input  fwp_src_t               rd_src_i,
  input  logic                   rd_play_i,
  output logic                   rd_ready_o,
  output logic                   rd_ack_o,
  output logic                   rd_play_o,
  output logic                   rd_error_o,
  output logic [FWP_RES_W-1:0]   rd_value_o,
  // Status
  output logic                   word_seen_o,
  output logic [FWP_PATHS-1:0]   path_configured_o
);

  logic [FWP_WORD_W-1:0]  word_w;
  logic [FWP_RES_W-1:0]   res [FWP_PATHS];
  logic [FWP_PATHS-1:0]   conf_w;
  logic                   cfg_load;
  logic                   cfg_ok;
  logic                   rd_take;

  fwp_state_t             st_reg;
  fwp_state_t             st_next;
  logic [5:0]             cnt_reg;
  logic [5:0]             cnt_next;
  logic                   pend_path_reg;
  logic                   pend_path_next;
  logic [FWP_SHIFT_W-1:0] pend_shift_reg;
  logic [FWP_SHIFT_W-1:0] pend_shift_next;
  logic [FWP_LEN_W-1:0]   pend_len_reg;
  logic [FWP_LEN_W-1:0]   pend_len_next;
  logic [FWP_OFS_W-1:0]   pend_ofs_reg;
  logic [FWP_OFS_W-1:0]   pend_ofs_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   cerr_reg;
  logic                   cerr_next;

  logic                   ack_reg;
  logic                   ack_next;
  logic                   play_reg;
  logic                   play_next;
  logic                   rerr_reg;
  logic                   rerr_next;
  logic [FWP_RES_W-1:0]   value_reg;
  logic [FWP_RES_W-1:0]   value_next;
  logic [FWP_RES_W-1:0]   sel_value;
  logic                   sel_ok;

  fwp_hold u_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (link_valid_i),
    .word_i  (link_word_i),
    .word_o  (word_w),
    .seen_o  (word_seen_o)
  );

  // One processing chain per path, A and B; legacy selectors share them
  for (genvar g = 0; g < FWP_PATHS; g++) begin : g_path
    fwp_path_if pif ();
    assign pif.load   = cfg_load && (pend_path_reg == 1'(g)); // RL9
    assign pif.shift  = pend_shift_reg;
    assign pif.length = pend_len_reg;
    assign pif.offset = pend_ofs_reg;
    assign pif.word   = word_w; // RL12
    assign res[g]     = pif.result; // RL14
    assign conf_w[g]  = pif.configured;
    fwp_path u_path (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .bus   (pif.path)
    );
  end

  // Configure operation
  assign cfg_ok = fwp_is_proc(cfg_path_i) &&
                  (cfg_length_i >= FWP_LEN_MIN) &&
                  (cfg_length_i <= FWP_LEN_MAX); // RL5
  assign cfg_load = (st_reg == FWP_ST_CFG) && (cnt_reg == FWP_CNT_ZERO);

  always_comb begin
    st_next         = st_reg;
    cnt_next        = cnt_reg;
    pend_path_next  = pend_path_reg;
    pend_shift_next = pend_shift_reg;
    pend_len_next   = pend_len_reg;
    pend_ofs_next   = pend_ofs_reg;
    done_next       = 1'b0;
    cerr_next       = 1'b0;
    unique case (st_reg)
      FWP_ST_IDLE: begin
        if (cfg_req_i) begin
          if (cfg_ok) begin
            st_next         = FWP_ST_CFG; // RL10
            cnt_next        = FWP_CFG_CYC - FWP_CNT_ONE;
            pend_path_next  = fwp_path_of(cfg_path_i); // RL13
            pend_shift_next = cfg_shift_i; // RL4
            pend_len_next   = cfg_length_i;
            pend_ofs_next   = cfg_offset_i; // RL6
          end else begin
            cerr_next = 1'b1;
          end
        end
      end
      FWP_ST_CFG: begin
        if (cnt_reg == FWP_CNT_ZERO) begin
          st_next   = FWP_ST_IDLE;
          done_next = 1'b1; // RL11
        end else begin
          cnt_next = cnt_reg - FWP_CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg         <= FWP_ST_IDLE;
      cnt_reg        <= FWP_CNT_ZERO;
      pend_path_reg  <= 1'b0;
      pend_shift_reg <= FWP_SHIFT_RST;
      pend_len_reg   <= FWP_LEN_RST;
      pend_ofs_reg   <= FWP_OFS_RST;
      done_reg       <= 1'b0;
      cerr_reg       <= 1'b0;
    end else begin
      st_reg         <= st_next;
      cnt_reg        <= cnt_next;
      pend_path_reg  <= pend_path_next;
      pend_shift_reg <= pend_shift_next;
      pend_len_reg   <= pend_len_next;
      pend_ofs_reg   <= pend_ofs_next;
      done_reg       <= done_next;
      cerr_reg       <= cerr_next;
    end
  end

  // Feedback read, refused while the sequencer is blocked
  assign rd_take = rd_req_i && (st_reg == FWP_ST_IDLE); // RL10

  always_comb begin
    sel_ok    = 1'b1;
    sel_value = {1'b0, word_w};
    case (rd_src_i) // RL14
      FWP_SRC_RAW:        sel_value = {1'b0, word_w}; // RL2
      FWP_SRC_PROC_A:     sel_value = res[0];
      FWP_SRC_PROC_B:     sel_value = res[1];
      FWP_SRC_LEGACY_FWD: sel_value = res[0]; // RL13
      FWP_SRC_LEGACY_DEC: sel_value = res[1]; // RL13
      default:            sel_ok    = 1'b0;
    endcase
  end

  always_comb begin
    ack_next   = rd_take && sel_ok; // RL15
    play_next  = rd_take && sel_ok && rd_play_i; // RL16
    rerr_next  = rd_take && !sel_ok;
    value_next = value_reg;
    if (rd_take && sel_ok) begin
      value_next = sel_value;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      play_reg  <= 1'b0;
      rerr_reg  <= 1'b0;
      value_reg <= FWP_RES_RST;
    end else begin
      ack_reg   <= ack_next;
      play_reg  <= play_next;
      rerr_reg  <= rerr_next;
      value_reg <= value_next;
    end
  end

  assign cfg_ready_o       = (st_reg == FWP_ST_IDLE);
  assign cfg_busy_o        = (st_reg == FWP_ST_CFG);
  assign cfg_done_o        = done_reg;
  assign cfg_error_o       = cerr_reg;
  assign rd_ready_o        = (st_reg == FWP_ST_IDLE);
  assign rd_ack_o          = ack_reg;
  assign rd_play_o         = play_reg;
  assign rd_error_o        = rerr_reg;
  assign rd_value_o        = value_reg;
  assign path_configured_o = conf_w;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_raw_exact: assert property ( // RL2
    rd_take && (rd_src_i == FWP_SRC_RAW) |=>
      rd_ack_o && (rd_value_o == {1'b0, $past(word_w)}))
    else $error("raw read did not return the held word");

  chk_cfg_blocks: assert property ( // RL10
    cfg_ready_o && cfg_req_i && cfg_ok |=>
      cfg_busy_o [*4] ##1 (cfg_done_o && cfg_ready_o))
    else $error("configure did not block for its full time");

  chk_read_refused: assert property ( // RL10
    cfg_busy_o |=> !rd_ack_o && !rd_play_o)
    else $error("read answered while configure was blocking");

  chk_bad_length: assert property ( // RL5
    cfg_ready_o && cfg_req_i &&
    ((cfg_length_i < FWP_LEN_MIN) || (cfg_length_i > FWP_LEN_MAX)) |=>
      cfg_error_o && !cfg_busy_o)
    else $error("illegal length was not rejected");

  chk_alias_fwd: assert property ( // RL13
    rd_take && (rd_src_i == FWP_SRC_LEGACY_FWD) |=>
      rd_value_o == $past(res[0]))
    else $error("forwarded-result selector is not path A");

  chk_alias_dec: assert property ( // RL13
    rd_take && (rd_src_i == FWP_SRC_LEGACY_DEC) |=>
      rd_value_o == $past(res[1]))
    else $error("decoder selector is not path B");

  // Path B result may only move with the word when path A loads
  chk_only_selected: assert property ( // RL9
    cfg_load && (pend_path_reg == 1'b0) |=>
      (res[1] == $past(res[1])) || (word_w != $past(word_w)))
    else $error("configure touched the other path");

  chk_play_index: assert property ( // RL16
    rd_take && sel_ok && rd_play_i |=>
      rd_play_o && rd_ack_o && (rd_value_o == $past(sel_value)))
    else $error("table play without the processed index");

  chk_config_sticks: assert property ( // RL8
    cfg_load |=> path_configured_o[$past(pend_path_reg)])
    else $error("path not marked configured after load");

  cov_cfg_done: cover property (cfg_req_i && cfg_ok ##5 cfg_done_o);
  cov_play:     cover property (rd_play_o);
  cov_reread:   cover property (cfg_done_o ##[1:8] rd_ack_o);
  cov_bad_cfg:  cover property (cfg_error_o);

endmodule // fwp_top

// file: test/fwp_link_model.sv
`timescale 1ns/1ns
module fwp_link_model
  import fwp_pkg::*;
(
  // Clock
  input  wire logic                  clk_i,
  // Link toward the block
  output logic                       link_valid_o,
  output logic [FWP_WORD_W-1:0]      link_word_o
);
  initial begin
    link_valid_o = 1'b0;
    link_word_o  = FWP_WORD_RST;
  end

  // One whole 16-bit word per pulse; line shows junk once released
  task automatic send(input logic [FWP_WORD_W-1:0] w);
    @(posedge clk_i);
    link_valid_o <= 1'b1;
    link_word_o  <= w;
    @(posedge clk_i);
    link_valid_o <= 1'b0;
    link_word_o  <= ~w;
  endtask

  // Two messages back to back, the second replaces the first
  task automatic send2(input logic [FWP_WORD_W-1:0] a,
                       input logic [FWP_WORD_W-1:0] b);
    @(posedge clk_i);
    link_valid_o <= 1'b1;
    link_word_o  <= a;
    @(posedge clk_i);
    link_word_o  <= b;
    @(posedge clk_i);
    link_valid_o <= 1'b0;
    link_word_o  <= ~b;
  endtask
endmodule // fwp_link_model

// file: test/fwp_top_tb.sv
`timescale 1ns/1ns
module fwp_top_tb;
  import fwp_pkg::*;
  logic                   clk_i;
  logic                   rst_i;
  logic                   link_valid_i;
  logic [FWP_WORD_W-1:0]  link_word_i;
  logic                   cfg_req_i;
  fwp_src_t               cfg_path_i;
  logic [FWP_SHIFT_W-1:0] cfg_shift_i;
  logic [FWP_LEN_W-1:0]   cfg_length_i;
  logic [FWP_OFS_W-1:0]   cfg_offset_i;
  logic                   cfg_ready_o;
  logic                   cfg_busy_o;
  logic                   cfg_done_o;
  logic                   cfg_error_o;
  logic                   rd_req_i;
  fwp_src_t               rd_src_i;
  logic                   rd_play_i;
  logic                   rd_ready_o;
  logic                   rd_ack_o;
  logic                   rd_play_o;
  logic                   rd_error_o;
  logic [FWP_RES_W-1:0]   rd_value_o;
  logic                   word_seen_o;
  logic [FWP_PATHS-1:0]   path_configured_o;
  int                     err_count;
  int                     samples_checked;
  int                     cycles;

  fwp_link_model link (
    .clk_i        (clk_i),
    .link_valid_o (link_valid_i),
    .link_word_o  (link_word_i)
  );

  fwp_top dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .link_valid_i      (link_valid_i),
    .link_word_i       (link_word_i),
    .cfg_req_i         (cfg_req_i),
    .cfg_path_i        (cfg_path_i),
    .cfg_shift_i       (cfg_shift_i),
    .cfg_length_i      (cfg_length_i),
    .cfg_offset_i      (cfg_offset_i),
    .cfg_ready_o       (cfg_ready_o),
    .cfg_busy_o        (cfg_busy_o),
    .cfg_done_o        (cfg_done_o),
    .cfg_error_o       (cfg_error_o),
    .rd_req_i          (rd_req_i),
    .rd_src_i          (rd_src_i),
    .rd_play_i         (rd_play_i),
    .rd_ready_o        (rd_ready_o),
    .rd_ack_o          (rd_ack_o),
    .rd_play_o         (rd_play_o),
    .rd_error_o        (rd_error_o),
    .rd_value_o        (rd_value_o),
    .word_seen_o       (word_seen_o),
    .path_configured_o (path_configured_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("Mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [16:0] seen,
                       input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Shift, mask to length bits, add offset
  function automatic logic [16:0] fe(input logic [15:0] w,
      input logic [3:0] s, input logic [4:0] l, input logic [11:0] o);
    logic [16:0] m;
    m = (17'h00001 << l) - 17'h00001;
    return (({1'b0, w} >> s) & m) + {5'h00, o};
  endfunction

  task automatic do_cfg(input fwp_src_t p, input logic [3:0] s,
      input logic [4:0] l, input logic [11:0] o, input logic bad);
    int n;
    int b;
    @(posedge clk_i);
    cfg_req_i    <= 1'b1;
    cfg_path_i   <= p;
    cfg_shift_i  <= s;
    cfg_length_i <= l;
    cfg_offset_i <= o;
    @(posedge clk_i);
    cfg_req_i <= 1'b0;
    // Read in the first blocked cycle must go unanswered
    rd_req_i  <= !bad;
    #1;
    n = 1;
    b = 0;
    while (cfg_done_o !== 1'b1 && cfg_error_o !== 1'b1 && n < 20) begin
      if (cfg_busy_o === 1'b1) b++;
      if (rd_ready_o !== 1'b0) b = b + 100;
      if (rd_ack_o === 1'b1) b = b + 1000;
      @(posedge clk_i);
      rd_req_i <= 1'b0;
      #1;
      n++;
    end
    check("cfg_cycles", 17'(n), bad ? 17'h00001 : 17'h00005);
    check("cfg_busy", 17'(b), bad ? 17'h00000 : 17'h00004);
    check("cfg_error", cfg_error_o, bad);
  endtask

  task automatic do_rd(input fwp_src_t s, input logic play,
                       input logic [16:0] exp);
    logic ok;
    ok = (s <= FWP_SRC_LEGACY_DEC);
    @(posedge clk_i);
    rd_req_i  <= 1'b1;
    rd_src_i  <= s;
    rd_play_i <= play;
    @(posedge clk_i);
    rd_req_i  <= 1'b0;
    rd_play_i <= 1'b0;
    #1;
    check("rd_ack", rd_ack_o, ok);
    check("rd_play", rd_play_o, play && ok);
    check("rd_error", rd_error_o, !ok);
    check("rd_value", rd_value_o, exp);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    err_count       = 0;
    samples_checked = 0;
    cycles          = 0;
    rst_i        = 1'b1;
    cfg_req_i    = 1'b0;
    cfg_path_i   = FWP_SRC_RAW;
    cfg_shift_i  = FWP_SHIFT_RST;
    cfg_length_i = FWP_LEN_RST;
    cfg_offset_i = FWP_OFS_RST;
    rd_req_i     = 1'b0;
    rd_src_i     = FWP_SRC_RAW;
    rd_play_i    = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("ready_rst", cfg_ready_o, 1'b1);
    check("seen_rst", word_seen_o, 1'b0);
    check("conf_rst", path_configured_o, 2'h0);
    check("value_rst", rd_value_o, FWP_RES_RST);
    link.send(16'hb6d5);
    #1;
    check("seen", word_seen_o, 1'b1);
    do_rd(FWP_SRC_RAW, 1'b0, 17'h0b6d5);
    do_rd(FWP_SRC_PROC_A, 1'b0, 17'h0b6d5);
    do_rd(FWP_SRC_LEGACY_DEC, 1'b0, 17'h0b6d5);
    do_cfg(FWP_SRC_PROC_A, 4'h2, 5'h01, 12'h000, 1'b0);
    check("conf_a", path_configured_o, 2'h1);
    do_rd(FWP_SRC_PROC_A, 1'b1, fe(16'hb6d5, 4'h2, 5'h01, 12'h000));
    do_rd(FWP_SRC_PROC_B, 1'b0, 17'h0b6d5);
    do_rd(FWP_SRC_RAW, 1'b0, 17'h0b6d5);
    do_cfg(FWP_SRC_LEGACY_DEC, 4'hf, 5'h10, 12'hfff, 1'b0);
    check("conf_ab", path_configured_o, 2'h3);
    do_rd(FWP_SRC_PROC_B, 1'b0, fe(16'hb6d5, 4'hf, 5'h10, 12'hfff));
    do_rd(FWP_SRC_LEGACY_FWD, 1'b0, fe(16'hb6d5, 4'h2, 5'h01, 12'h000));
    do_cfg(FWP_SRC_PROC_A, 4'h4, 5'h0c, 12'h020, 1'b0);
    do_rd(FWP_SRC_PROC_A, 1'b1, fe(16'hb6d5, 4'h4, 5'h0c, 12'h020));
    do_cfg(FWP_SRC_RAW, 4'h0, 5'h04, 12'h000, 1'b1);
    do_cfg(FWP_SRC_PROC_B, 4'h0, 5'h00, 12'h000, 1'b1);
    do_rd(FWP_SRC_PROC_B, 1'b0, fe(16'hb6d5, 4'hf, 5'h10, 12'hfff));
    do_cfg(FWP_SRC_PROC_A, 4'h0, 5'h10, 12'hfff, 1'b0);
    link.send2(16'h1234, 16'hffff);
    do_rd(FWP_SRC_PROC_A, 1'b0, fe(16'hffff, 4'h0, 5'h10, 12'hfff));
    do_rd(FWP_SRC_RAW, 1'b0, 17'h0ffff);
    do_rd(fwp_src_t'(3'h6), 1'b1, 17'h0ffff);
    report_and_stop();
  end
endmodule // fwp_top_tb
